//--- calib_pkg.sv
// calib_pkg: constants shared by the result correction stage
// assumes a 12-bit converter result and a single system clock
package calib_pkg;
    localparam int          RES_W          = 12;
    localparam int          GAIN_W         = 16;
    localparam int          GAIN_FRAC      = 12;
    localparam int          OFFS_W         = 16;
    localparam int          EXTRA_LATENCY  = 14;
    localparam int          LAT_W          = 4;
    localparam int          CAP_SEL_W      = 3;
    localparam int          FLASH_ADDR_W   = 8;
    localparam int          FLASH_DATA_W   = 16;
    localparam logic [7:0]  GAIN_ADDR      = 8'h00;
    localparam logic [7:0]  OFFS_ADDR      = 8'h01;
    localparam logic [15:0] GAIN_RESET     = 16'h1000;
    localparam logic [15:0] OFFS_RESET     = 16'h0000;
    localparam logic [11:0] RES_MAX        = 12'hFFF;
    localparam logic [11:0] RES_MIN        = 12'h000;
    // start-up hold-off per capacitor selection, in microseconds; selection 0 is the sim-only 0 uF
    localparam int          CLK_MHZ        = 250;
    localparam int          SIM_DELAY_CYC  = 16;
    localparam int          DELAY_W        = 24;
    localparam int          CAP_DELAY_US [8] = '{0, 1000, 2000, 4000, 8000, 16000, 32000, 50000};
    typedef enum logic [1:0] {FETCH_GAIN, WAIT_GAIN, WAIT_OFFS, RUN} fetch_t;
endpackage

//--- calib_delay_line.sv
// calib_delay_line: fixed-length shift register for data and a strobe
// assumes a common clock, active-low asynchronous reset and clock enable
`timescale 1ns/100ps
module calib_delay_line #(
    parameter int W     = 12,
    parameter int DEPTH = 14
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    input  wire logic         vin,
    output logic      [W-1:0] dout,
    output logic              vout
);
    logic [W-1:0] data_r  [DEPTH];
    logic [DEPTH-1:0] val_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) data_r[i] <= '0;
        end else if (ce) begin
            data_r[0] <= din;
            for (int i = 1; i < DEPTH; i++) data_r[i] <= data_r[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            val_r <= '0;
        end else if (ce) begin
            val_r <= {val_r[DEPTH-2:0], vin};
        end
    end

    assign dout = data_r[DEPTH-1];
    assign vout = val_r[DEPTH-1];
endmodule // calib_delay_line

//--- adc_result_calibration.sv
// adc_result_calibration: gain/offset correction of converter results
// assumes flash answers a read one cycle after FLASH_RD, converter results are synchronous
// assumes CALIB_EN is changed only while no conversion is in flight
`timescale 1ns/100ps
module adc_result_calibration
    import calib_pkg::*;
(
    // clock, reset, enable
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic                    CE,
    // configuration
    input  wire logic                    CALIB_EN,
    input  wire logic                    SAT_BYPASS,
    input  wire logic [CAP_SEL_W-1:0]    CAP_SEL,
    // converter side
    input  wire logic [RES_W-1:0]        ADC_RESULT,
    input  wire logic                    ADC_VALID,
    input  wire logic                    ADC_BUSY,
    // flash read port
    output logic                         FLASH_RD,
    output logic      [FLASH_ADDR_W-1:0] FLASH_ADDR,
    input  wire logic [FLASH_DATA_W-1:0] FLASH_DATA,
    // downstream
    output logic      [RES_W-1:0]        CONVERSION_RESULT,
    output logic                         RESULT_VALID,
    output logic                         BUSY,
    output logic                         SAMPLE_ENABLE,
    output logic                         COEF_READY
);
    ////////////////////////////////////////////////////////////////////////
    fetch_t                  fetch_r;
    logic [GAIN_W-1:0]       gain_r;
    logic [OFFS_W-1:0]       offs_r;
    logic [DELAY_W-1:0]      hold_r;
    logic                    hold_done_r;
    logic [RES_W-1:0]        corr_r;
    logic                    cvalid_r;
    logic [RES_W-1:0]        line_d;
    logic                    line_v;
    logic [RES_W-1:0]        raw_out_r;
    logic                    raw_v_r;
    logic [LAT_W:0]          inflight_r;

    // hold-off length per selection; the zero selection is for simulation only
    function automatic logic [DELAY_W-1:0] hold_len(input logic [CAP_SEL_W-1:0] sel);
        if (sel == '0)
            return DELAY_W'(SIM_DELAY_CYC);
        return DELAY_W'(CAP_DELAY_US[sel] * CLK_MHZ);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // start-up hold-off; capacitor selection is sampled only while counting
    logic [DELAY_W-1:0] hold_limit;
    assign hold_limit = hold_len(CAP_SEL) - DELAY_W'(1);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_r      <= '0;
            hold_done_r <= 1'b0;
        end else if (CE && !hold_done_r) begin
            if (hold_r >= hold_limit)
                hold_done_r <= 1'b1;
            else
                hold_r <= hold_r + DELAY_W'(1);
        end
    end

    assign SAMPLE_ENABLE = hold_done_r;

    ////////////////////////////////////////////////////////////////////////
    // coefficient fetch; identity coefficients until flash has answered
    // the fetch runs once per reset, so new flash words need a reset to take effect
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_r <= FETCH_GAIN;
            gain_r  <= GAIN_RESET;
            offs_r  <= OFFS_RESET;
        end else if (CE) begin
            unique case (fetch_r)
                FETCH_GAIN: fetch_r <= WAIT_GAIN;
                WAIT_GAIN: begin
                    gain_r  <= FLASH_DATA;
                    fetch_r <= WAIT_OFFS;
                end
                WAIT_OFFS: begin
                    offs_r  <= FLASH_DATA;
                    fetch_r <= RUN;
                end
                RUN: fetch_r <= RUN;
            endcase
        end
    end

    assign FLASH_RD   = (fetch_r == FETCH_GAIN) || (fetch_r == WAIT_GAIN);
    assign FLASH_ADDR = (fetch_r == FETCH_GAIN) ? GAIN_ADDR : OFFS_ADDR;
    assign COEF_READY = (fetch_r == RUN);

    ////////////////////////////////////////////////////////////////////////
    // correction, one cycle; the delay line adds the rest of the latency
    // two spare top bits keep the product positive for any gain word
    logic signed [GAIN_W+RES_W+1:0] prod;
    logic signed [GAIN_W+RES_W+1:0] sum;
    logic                           raw_sat;
    logic                           calib_take;
    logic [RES_W-1:0]               corr_nxt;

    assign calib_take = ADC_VALID && CALIB_EN;
    assign raw_sat    = (ADC_RESULT == RES_MAX) || (ADC_RESULT == RES_MIN);

    // clamping keeps a large offset from wrapping a result around the code range
    always_comb begin
        prod     = $signed({2'b00, gain_r}) * $signed({2'b00, ADC_RESULT});
        sum      = (prod >>> GAIN_FRAC)
                 + (GAIN_W+RES_W+2)'($signed(offs_r));
        corr_nxt = sum[RES_W-1:0];
        if (SAT_BYPASS && raw_sat)
            corr_nxt = ADC_RESULT;
        else if (sum < 0)
            corr_nxt = RES_MIN;
        else if (sum > $signed({{(GAIN_W+2){1'b0}}, RES_MAX}))
            corr_nxt = RES_MAX;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            corr_r <= '0;
        end else if (CE) begin
            corr_r <= corr_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cvalid_r <= 1'b0;
        end else if (CE) begin
            cvalid_r <= calib_take;
        end
    end

    // the raw path has one register too, so all fourteen extra stages live here
    calib_delay_line #(
        .W     (RES_W),
        .DEPTH (EXTRA_LATENCY)
    ) u_delay (
        .clk   (CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .din   (corr_r),
        .vin   (cvalid_r),
        .dout  (line_d),
        .vout  (line_v)
    );

    ////////////////////////////////////////////////////////////////////////
    // uncorrected path, registered so the base latency is one cycle
    logic raw_take;
    assign raw_take = ADC_VALID && !CALIB_EN;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            raw_out_r <= '0;
            raw_v_r   <= 1'b0;
        end else if (CE) begin
            raw_v_r <= raw_take;
            if (raw_take)
                raw_out_r <= ADC_RESULT;
        end
    end

    // corrected results inside the pipe keep busy high after the converter finishes; raw results do not
    // five bits cover a full pipe of back-to-back results
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            inflight_r <= '0;
        end else if (CE) begin
            if (calib_take && !line_v)
                inflight_r <= inflight_r + (LAT_W+1)'(1);
            else if (!calib_take && line_v && inflight_r != '0)
                inflight_r <= inflight_r - (LAT_W+1)'(1);
        end
    end

    // toggling CALIB_EN mid-stream may drop results in flight; change it only when idle
    logic [RES_W-1:0] out_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_r <= '0;
        end else if (CE) begin
            if (line_v)
                out_r <= line_d;
            else if (raw_v_r)
                out_r <= raw_out_r;
        end
    end

    // strobe is gated by CE so a frozen pipe never shows one result twice
    logic valid_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            valid_r <= 1'b0;
        else if (CE)
            valid_r <= line_v || raw_v_r;
    end

    assign CONVERSION_RESULT = out_r;
    assign RESULT_VALID      = valid_r && CE;
    assign BUSY              = ADC_BUSY || (CALIB_EN && inflight_r != '0);
endmodule // adc_result_calibration

//--- calib_flash_model.sv
// flash model holding the gain and offset words
// assumes one-cycle read latency on the system clock
`timescale 1ns/100ps
module calib_flash_model
    import calib_pkg::*;
(
    input  wire logic [FLASH_ADDR_W-1:0] addr,
    input  wire logic                    clk,
    input  wire logic                    rd,
    input  wire logic [FLASH_DATA_W-1:0] gain,
    input  wire logic [FLASH_DATA_W-1:0] offs,
    output logic      [FLASH_DATA_W-1:0] data
);
    // words assume the 2.56 V reference
    // idle bus toggles so stale data is never taken as an answer
    always_ff @(posedge clk) begin
        data <= !rd ? ~data : (addr == GAIN_ADDR ? gain : offs);
    end
endmodule // calib_flash_model

//--- adc_result_calibration_properties.sv
// checker for the result correction stage
// assumes CE stays high and CALIB_EN only changes while idle
`timescale 1ns/100ps
module adc_result_calibration_properties
    import calib_pkg::*;
(
    input wire logic                    CLK, RST_N, CE, CALIB_EN, SAT_BYPASS,
    input wire logic [CAP_SEL_W-1:0]    CAP_SEL,
    input wire logic [RES_W-1:0]        ADC_RESULT, CONVERSION_RESULT,
    input wire logic                    ADC_VALID, ADC_BUSY, FLASH_RD,
    input wire logic [FLASH_ADDR_W-1:0] FLASH_ADDR,
    input wire logic [FLASH_DATA_W-1:0] FLASH_DATA,
    input wire logic                    RESULT_VALID, BUSY, SAMPLE_ENABLE, COEF_READY
);
    logic [7:0] up_cnt_r;
    // saturates so it never wraps back into the hold-off window
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            up_cnt_r <= 8'h00;
        end else if (up_cnt_r != 8'hFF) begin
            up_cnt_r <= up_cnt_r + 8'h01;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    lat_calib_a: assert property (ADC_VALID && CE && CALIB_EN |-> ##16 RESULT_VALID)
        else $error("late corrected result");
    lat_raw_a: assert property (ADC_VALID && CE && !CALIB_EN |-> ##2 RESULT_VALID)
        else $error("late raw result");
    valid_cause_a: assert property (RESULT_VALID && CALIB_EN |-> $past(ADC_VALID, 16))
        else $error("strobe without conversion");
    raw_pass_a: assert property (ADC_VALID && !CALIB_EN |-> ##2
        CONVERSION_RESULT == $past(ADC_RESULT, 2))
        else $error("raw path altered value");
    sat_pass_a: assert property (ADC_VALID && CALIB_EN && SAT_BYPASS &&
        (ADC_RESULT == RES_MAX || ADC_RESULT == RES_MIN) |-> ##16
        CONVERSION_RESULT == $past(ADC_RESULT, 16))
        else $error("saturated value corrected");
    busy_src_a: assert property (ADC_BUSY |-> BUSY)
        else $error("busy lost");
    busy_flight_a: assert property (ADC_VALID && CALIB_EN |=> BUSY[*8])
        else $error("not busy in flight");
    fetch_seq_a: assert property (RST_N && FLASH_RD && FLASH_ADDR == GAIN_ADDR |=>
        FLASH_RD && FLASH_ADDR == OFFS_ADDR ##1 !FLASH_RD ##1 COEF_READY)
        else $error("coefficient fetch order");
    coef_hold_a: assert property (COEF_READY |=> COEF_READY)
        else $error("coefficients dropped");
    hold_off_a: assert property (CAP_SEL == 3'h0 && up_cnt_r < 8'h0E |-> !SAMPLE_ENABLE)
        else $error("sampling too early");
    short_sim_a: assert property (CAP_SEL == 3'h0 && up_cnt_r == 8'h14 |-> SAMPLE_ENABLE)
        else $error("hold-off too long");
    cover property (ADC_VALID && CALIB_EN);
    cover property (ADC_VALID && SAT_BYPASS && ADC_RESULT == RES_MAX);
    cover property ($rose(COEF_READY));
endmodule // adc_result_calibration_properties
bind adc_result_calibration adc_result_calibration_properties chk_i (.CLK(CLK), .RST_N(RST_N),
    .CE(CE), .CALIB_EN(CALIB_EN), .SAT_BYPASS(SAT_BYPASS), .CAP_SEL(CAP_SEL), .ADC_BUSY(ADC_BUSY),
    .ADC_RESULT(ADC_RESULT), .ADC_VALID(ADC_VALID), .FLASH_RD(FLASH_RD), .BUSY(BUSY),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .CONVERSION_RESULT(CONVERSION_RESULT),
    .RESULT_VALID(RESULT_VALID), .SAMPLE_ENABLE(SAMPLE_ENABLE), .COEF_READY(COEF_READY));

//--- adc_result_calibration_tb.sv
// self-checking bench for the result correction stage
// assumes the flash model answers the coefficient fetch
`timescale 1ns/100ps
module adc_result_calibration_tb import calib_pkg::*;;
    logic                    CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, CALIB_EN = 1'b1;
    logic                    SAT_BYPASS = 1'b0, ADC_VALID = 1'b0, ADC_BUSY = 1'b0;
    logic [CAP_SEL_W-1:0]    CAP_SEL = 3'h0;
    logic [RES_W-1:0]        ADC_RESULT = 12'h000, CONVERSION_RESULT;
    logic [FLASH_DATA_W-1:0] gain = GAIN_RESET, offs = OFFS_RESET, FLASH_DATA;
    logic [FLASH_ADDR_W-1:0] FLASH_ADDR;
    logic                    FLASH_RD, RESULT_VALID, BUSY, SAMPLE_ENABLE, COEF_READY;
    int                      mismatches = 0, check_count = 0;
    always #2 CLK = ~CLK;
    adc_result_calibration uut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .CALIB_EN(CALIB_EN),
        .SAT_BYPASS(SAT_BYPASS), .CAP_SEL(CAP_SEL), .ADC_RESULT(ADC_RESULT),
        .ADC_VALID(ADC_VALID), .ADC_BUSY(ADC_BUSY), .FLASH_RD(FLASH_RD),
        .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .CONVERSION_RESULT(CONVERSION_RESULT),
        .RESULT_VALID(RESULT_VALID), .BUSY(BUSY), .SAMPLE_ENABLE(SAMPLE_ENABLE),
        .COEF_READY(COEF_READY));
    calib_flash_model flash_i (.clk(CLK), .rd(FLASH_RD), .addr(FLASH_ADDR), .gain(gain),
        .offs(offs), .data(FLASH_DATA));
    task automatic chk(input logic [RES_W-1:0] act, exp);
        check_count++;
        if (act !== exp) begin
            mismatches++;
            $display("BAD %0t result %h not %h", $time, act, exp);
        end
    endtask
    task automatic chk_bit(input logic act, exp);
        check_count++;
        if (act !== exp) begin
            mismatches++;
            $display("BAD %0t flag %b not %b", $time, act, exp);
        end
    endtask
    task automatic chk_lat(input int act, exp);
        check_count++;
        if (act != exp) begin
            mismatches++;
            $display("BAD %0t latency %0d not %0d", $time, act, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // new coefficients only take effect through a reset, as the fetch runs once
    task automatic do_reset(input logic [15:0] g, o);
        int n;
        @(posedge CLK);
        gain <= g;
        offs <= o;
        RST_N <= 1'b0;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        #1;
        chk_bit(SAMPLE_ENABLE, 1'b0);
        n = 0;
        while (SAMPLE_ENABLE !== 1'b1 && n < 30) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk_bit(SAMPLE_ENABLE, 1'b1);
        chk_bit(COEF_READY, 1'b1);
    endtask
    task automatic convert(input logic [RES_W-1:0] raw, exp);
        int n;
        @(posedge CLK);
        ADC_RESULT <= raw;
        ADC_VALID <= 1'b1;
        @(posedge CLK);
        ADC_VALID <= 1'b0;
        ADC_RESULT <= ~raw;
        #1;
        chk_bit(BUSY, CALIB_EN);
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (RESULT_VALID !== 1'b1 && n < 40);
        chk_lat(n, CALIB_EN ? 1 + EXTRA_LATENCY : 1);
        chk(CONVERSION_RESULT, exp);
        chk_bit(RESULT_VALID, 1'b1);
        @(posedge CLK);
        #1;
        chk_bit(RESULT_VALID, 1'b0);
        chk(CONVERSION_RESULT, exp);
    endtask
    task automatic t_identity();
        do_reset(GAIN_RESET, OFFS_RESET);
        convert(12'h123, 12'h123);
        convert(12'hABC, 12'hABC);
    endtask
    task automatic t_gain();
        do_reset(16'h0800, 16'h0003);
        convert(12'h100, 12'h083);
        convert(12'hFFF, 12'h802);
        convert(12'h000, 12'h003);
    endtask
    task automatic t_bypass();
        @(posedge CLK);
        SAT_BYPASS <= 1'b1;
        convert(12'hFFF, 12'hFFF);
        convert(12'h000, 12'h000);
        convert(12'h100, 12'h083);
        @(posedge CLK);
        CALIB_EN <= 1'b0;
        convert(12'h100, 12'h100);
        @(posedge CLK);
        ADC_BUSY <= 1'b1;
        @(posedge CLK);
        #1;
        chk_bit(BUSY, 1'b1);
        @(posedge CLK);
        ADC_BUSY <= 1'b0;
    endtask
    initial begin
        t_identity();
        t_gain();
        t_bypass();
        summarize();
    end
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
endmodule // adc_result_calibration_tb
